// ### pin_function_select.sv
// pin function selector for port pins 8 to 22 with axi4-lite registers
`timescale 1ns/10ps
module pin_function_select
  import pin_function_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // operating mode straps
  input wire logic i_single_chip,
  input wire logic i_rom_disabled,
  input wire logic i_large_package,
  // axi4-lite write address
  input wire logic [3:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  // axi4-lite write data
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  // axi4-lite write response
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  // axi4-lite read address
  input wire logic [3:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  // axi4-lite read data
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // general purpose port side, indexed by pin number
  input wire logic [22:8] i_gpio_out,
  input wire logic [22:8] i_gpio_oe,
  // on-chip function outputs toward the pins
  input wire logic i_upper_word_low_byte_write_strobe,
  input wire logic i_column_strobe_upper_upper,
  input wire logic i_column_strobe_upper_lower,
  input wire logic i_bus_release_ack,
  input wire logic i_dma1_request_accepted,
  input wire logic i_dma0_request_accepted,
  input wire logic i_address_hold_strobe,
  input wire logic i_system_clock,
  input wire logic i_read_strobe,
  input wire logic i_upper_byte_write_strobe,
  input wire logic i_lower_byte_write_strobe,
  input wire logic i_chip_select_one,
  input wire logic i_chip_select_zero,
  // pad side
  input wire logic [22:8] i_pin,
  output logic [22:8] o_pin_out,
  output logic [22:8] o_pin_oe,
  // pin inputs routed to on-chip functions
  output logic o_bus_release_request,
  output logic o_wait_request,
  output logic o_timer_ext_clock_c,
  output logic o_timer_ext_clock_d,
  output logic o_ext_interrupt_two,
  output logic o_ext_interrupt_three
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [15:0] high_ff;
  logic [15:0] middle_ff;
  logic [15:0] low_ff;
  logic init_pending_ff;
  logic aw_full_ff;
  logic w_full_ff;
  logic [3:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic [22:8] pin_out_ff;
  logic [22:8] pin_oe_ff;
  logic bus_req_ff;
  logic wait_req_ff;
  logic tclk_c_ff;
  logic tclk_d_ff;
  logic ext_interrupt_two_ff;
  logic ext_interrupt_three_ff;

  logic do_write;
  logic addr_ok_w;
  logic [15:0] wmask;

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------

  // address and data are latched independently, in either order
  assign do_write = aw_full_ff && w_full_ff && !bvalid_ff;
  assign addr_ok_w = (awaddr_ff == ADDR_HIGH) || (awaddr_ff == ADDR_MIDDLE)
                     || (awaddr_ff == ADDR_LOW);
  assign wmask = {{8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};

  // write address and data holding registers
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      aw_full_ff <= 1'b0;
      w_full_ff <= 1'b0;
      awaddr_ff <= 4'h0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end
    else
    begin
      if (i_awvalid && awready_ff)
      begin
        aw_full_ff <= 1'b1;
        awaddr_ff <= i_awaddr;
      end
      else if (do_write)
        aw_full_ff <= 1'b0;
      if (i_wvalid && wready_ff)
      begin
        w_full_ff <= 1'b1;
        wdata_ff <= i_wdata;
        wstrb_ff <= i_wstrb;
      end
      else if (do_write)
        w_full_ff <= 1'b0;
    end
  end

  // ready only while the holding slot is empty; held off until init load
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
    end
    else
    begin
      awready_ff <= !init_pending_ff && !aw_full_ff && !(i_awvalid && awready_ff);
      wready_ff <= !init_pending_ff && !w_full_ff && !(i_wvalid && wready_ff);
    end
  end

  // write response, slverr on unmapped or read-only offsets
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid_ff <= 1'b1;
      bresp_ff <= addr_ok_w ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bvalid_ff && i_bready)
      bvalid_ff <= 1'b0;
  end

  // ----------------------------------------------------------------
  // selector registers
  // ----------------------------------------------------------------

  // only the power-on reset clears these; no other reset source
  // reaches this block, so sleep and soft resets keep contents
  // middle value depends on the mode strap, which cannot feed an async
  // reset, so it is loaded on the first edge after release
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      init_pending_ff <= 1'b1;
    else
      init_pending_ff <= 1'b0;
  end

  // reserved positions are masked on write so they always read zero
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      high_ff <= RST_HIGH;
    else if (do_write && awaddr_ff == ADDR_HIGH)
      high_ff <= (high_ff & ~(wmask & MASK_HIGH)) | (wdata_ff[15:0] & wmask & MASK_HIGH);
  end

  // middle selector, strap-dependent load then software writes
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      middle_ff <= RST_MIDDLE_SINGLE;
    else if (init_pending_ff)
      middle_ff <= i_single_chip ? RST_MIDDLE_SINGLE : RST_MIDDLE_EXT;
    else if (do_write && awaddr_ff == ADDR_MIDDLE)
      middle_ff <= (middle_ff & ~(wmask & MASK_MIDDLE))
                   | (wdata_ff[15:0] & wmask & MASK_MIDDLE);
  end

  // low selector is storage only here; its pins live elsewhere
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      low_ff <= RST_LOW;
    else if (do_write && awaddr_ff == ADDR_LOW)
      low_ff <= (low_ff & ~(wmask & MASK_LOW)) | (wdata_ff[15:0] & wmask & MASK_LOW);
  end

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------

  // one read in flight; arready drops while the answer waits
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= RESP_OKAY;
    end
    else if (i_arvalid && arready_ff)
    begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rresp_ff <= RESP_OKAY;
      unique case (i_araddr)
        ADDR_HIGH: rdata_ff <= {16'h0000, high_ff};
        ADDR_MIDDLE: rdata_ff <= {16'h0000, middle_ff};
        ADDR_LOW: rdata_ff <= {16'h0000, low_ff};
        ADDR_MODE: rdata_ff <= {28'h000_0000, init_pending_ff, i_large_package,
                                i_rom_disabled, i_single_chip};
        default:
        begin
          rdata_ff <= 32'h0000_0000;
          rresp_ff <= RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_ff && i_rready)
    begin
      rvalid_ff <= 1'b0;
      arready_ff <= 1'b1;
    end
    else if (!rvalid_ff)
      arready_ff <= 1'b1;
  end

  // ----------------------------------------------------------------
  // effective pin functions
  // ----------------------------------------------------------------
  logic bus_ok;
  logic rom_force;
  logic [22:8] nxt_pin_out;
  logic [22:8] nxt_pin_oe;
  logic nxt_bus_req;
  logic nxt_wait_req;
  logic nxt_tclk_c;
  logic nxt_tclk_d;
  logic nxt_ext_interrupt_two;
  logic nxt_ext_interrupt_three;

  // bus and dma functions are dropped in single chip mode
  assign bus_ok = !i_single_chip;
  // rom-disabled boot needs strobes and selects whatever the fields say
  assign rom_force = i_rom_disabled && !i_single_chip;

  // per-pin mux; default is the general purpose path
  always_comb
  begin
    nxt_pin_out = i_gpio_out;
    nxt_pin_oe = i_gpio_oe;
    nxt_bus_req = IDLE_ACTIVE_LOW;
    nxt_wait_req = IDLE_ACTIVE_LOW;
    nxt_tclk_c = IDLE_TIMER_CLK;
    nxt_tclk_d = IDLE_TIMER_CLK;
    nxt_ext_interrupt_two = IDLE_ACTIVE_LOW;
    nxt_ext_interrupt_three = IDLE_ACTIVE_LOW;
    if ((high_ff[HI_PIN22] && bus_ok) || rom_force)
    begin
      nxt_pin_out[22] = i_upper_word_low_byte_write_strobe;
      nxt_pin_oe[22] = 1'b1;
    end
    if (high_ff[HI_PIN21] && bus_ok)
    begin
      nxt_pin_out[21] = i_column_strobe_upper_upper;
      nxt_pin_oe[21] = 1'b1;
    end
    if (high_ff[HI_PIN20] && bus_ok)
    begin
      nxt_pin_out[20] = i_column_strobe_upper_lower;
      nxt_pin_oe[20] = 1'b1;
    end
    // code 11 is reserved and falls through to general purpose
    if (bus_ok && high_ff[HI_PIN19+:2] == CODE_ALT1)
    begin
      nxt_pin_out[19] = i_bus_release_ack;
      nxt_pin_oe[19] = 1'b1;
    end
    else if (bus_ok && high_ff[HI_PIN19+:2] == CODE_ALT2)
    begin
      nxt_pin_out[19] = i_dma1_request_accepted;
      nxt_pin_oe[19] = 1'b1;
    end
    if (bus_ok && high_ff[HI_PIN18+:2] == CODE_ALT1)
    begin
      nxt_pin_oe[18] = 1'b0;
      nxt_bus_req = i_pin[18];
    end
    else if (bus_ok && high_ff[HI_PIN18+:2] == CODE_ALT2)
    begin
      nxt_pin_out[18] = i_dma0_request_accepted;
      nxt_pin_oe[18] = 1'b1;
    end
    if (high_ff[HI_PIN17] && bus_ok)
    begin
      nxt_pin_oe[17] = 1'b0;
      nxt_wait_req = i_pin[17];
    end
    if (high_ff[HI_PIN16] && bus_ok)
    begin
      nxt_pin_out[16] = i_address_hold_strobe;
      nxt_pin_oe[16] = 1'b1;
    end
    // small packages have no pads here; keep them quiet
    if (!i_large_package)
    begin
      nxt_pin_out[22:16] = 7'h00;
      nxt_pin_oe[22:16] = 7'h00;
      nxt_bus_req = IDLE_ACTIVE_LOW;
      nxt_wait_req = IDLE_ACTIVE_LOW;
    end
    // clock output is not a bus function, allowed in every mode
    if (middle_ff[MID_PIN15])
    begin
      nxt_pin_out[15] = i_system_clock;
      nxt_pin_oe[15] = 1'b1;
    end
    if ((middle_ff[MID_PIN14] && bus_ok) || rom_force)
    begin
      nxt_pin_out[14] = i_read_strobe;
      nxt_pin_oe[14] = 1'b1;
    end
    if ((middle_ff[MID_PIN13] && bus_ok) || rom_force)
    begin
      nxt_pin_out[13] = i_upper_byte_write_strobe;
      nxt_pin_oe[13] = 1'b1;
    end
    if ((middle_ff[MID_PIN12] && bus_ok) || rom_force)
    begin
      nxt_pin_out[12] = i_lower_byte_write_strobe;
      nxt_pin_oe[12] = 1'b1;
    end
    if ((middle_ff[MID_PIN11] && bus_ok) || rom_force)
    begin
      nxt_pin_out[11] = i_chip_select_one;
      nxt_pin_oe[11] = 1'b1;
    end
    if ((middle_ff[MID_PIN10] && bus_ok) || rom_force)
    begin
      nxt_pin_out[10] = i_chip_select_zero;
      nxt_pin_oe[10] = 1'b1;
    end
    // timer and interrupt inputs work in every mode; 11 stays gpio
    if (middle_ff[MID_PIN9+:2] == CODE_ALT1)
    begin
      nxt_pin_oe[9] = 1'b0;
      nxt_tclk_d = i_pin[9];
    end
    else if (middle_ff[MID_PIN9+:2] == CODE_ALT2)
    begin
      nxt_pin_oe[9] = 1'b0;
      nxt_ext_interrupt_three = i_pin[9];
    end
    if (middle_ff[MID_PIN8+:2] == CODE_ALT1)
    begin
      nxt_pin_oe[8] = 1'b0;
      nxt_tclk_c = i_pin[8];
    end
    else if (middle_ff[MID_PIN8+:2] == CODE_ALT2)
    begin
      nxt_pin_oe[8] = 1'b0;
      nxt_ext_interrupt_two = i_pin[8];
    end
  end

  // registered pad and peripheral side; adds one cycle of latency
  // to every routed signal, traded for clean flop-driven outputs
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      pin_out_ff <= 15'h0000;
      pin_oe_ff <= 15'h0000;
      bus_req_ff <= IDLE_ACTIVE_LOW;
      wait_req_ff <= IDLE_ACTIVE_LOW;
      tclk_c_ff <= IDLE_TIMER_CLK;
      tclk_d_ff <= IDLE_TIMER_CLK;
      ext_interrupt_two_ff <= IDLE_ACTIVE_LOW;
      ext_interrupt_three_ff <= IDLE_ACTIVE_LOW;
    end
    else
    begin
      pin_out_ff <= nxt_pin_out;
      pin_oe_ff <= nxt_pin_oe;
      bus_req_ff <= nxt_bus_req;
      wait_req_ff <= nxt_wait_req;
      tclk_c_ff <= nxt_tclk_c;
      tclk_d_ff <= nxt_tclk_d;
      ext_interrupt_two_ff <= nxt_ext_interrupt_two;
      ext_interrupt_three_ff <= nxt_ext_interrupt_three;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_awready = awready_ff;
  assign o_wready = wready_ff;
  assign o_bvalid = bvalid_ff;
  assign o_bresp = bresp_ff;
  assign o_arready = arready_ff;
  assign o_rvalid = rvalid_ff;
  assign o_rdata = rdata_ff;
  assign o_rresp = rresp_ff;
  assign o_pin_out = pin_out_ff;
  assign o_pin_oe = pin_oe_ff;
  assign o_bus_release_request = bus_req_ff;
  assign o_wait_request = wait_req_ff;
  assign o_timer_ext_clock_c = tclk_c_ff;
  assign o_timer_ext_clock_d = tclk_d_ff;
  assign o_ext_interrupt_two = ext_interrupt_two_ff;
  assign o_ext_interrupt_three = ext_interrupt_three_ff;

endmodule : pin_function_select

// ### pin_function_pkg.sv
// constants for the port pin function selector block
//
// Contract
// - reserved selector bits read back as zero
// - high bit 12 selects pin 22 strobe
// - high bit 10 selects pin 21 strobe
// - high bit 8 selects pin 20 strobe
// - high bits 7:6 choose pin 19 function
// - high bits 5:4 choose pin 18 function
// - high bit 2 selects pin 17 wait input
// - high bit 0 selects pin 16 hold strobe
// - single chip mode blocks bus and dma functions
// - rom disabled forces the pin 22 (large package only) and pin 14 to 10 strobe and select functions, outside single chip mode
// - power-on loads middle by mode, low zero
// - other resets and sleep keep selector contents
// - middle bit 14 selects clock output, mode reset
// - middle bit 12 selects pin 14 read strobe
// - middle bit 10 selects pin 13 strobe
// - middle bit 8 selects pin 12 strobe
// - middle bit 6 selects chip select one
// - middle bit 4 selects chip select zero
// - middle bits 3:2 choose pin 9 function
// - middle bits 1:0 choose pin 8 function
// - operating mode may override selected functions
// - high selector drives pins on large package only
package pin_function_pkg;

  // ----------------------------------------------------------------
  // register map, byte addresses on the axi4-lite slave
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_HIGH = 4'h0;
  localparam logic [3:0] ADDR_MIDDLE = 4'h4;
  localparam logic [3:0] ADDR_LOW = 4'h8;
  localparam logic [3:0] ADDR_MODE = 4'hC;

  // ----------------------------------------------------------------
  // writable bit masks and reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] MASK_HIGH = 16'h55F5;
  localparam logic [15:0] MASK_MIDDLE = 16'h555F;
  localparam logic [15:0] MASK_LOW = 16'hFD75;
  localparam logic [15:0] RST_HIGH = 16'h0000;
  localparam logic [15:0] RST_MIDDLE_EXT = 16'h4000;
  localparam logic [15:0] RST_MIDDLE_SINGLE = 16'h0000;
  localparam logic [15:0] RST_LOW = 16'h0000;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int HI_PIN22 = 12;
  localparam int HI_PIN21 = 10;
  localparam int HI_PIN20 = 8;
  localparam int HI_PIN19 = 6;
  localparam int HI_PIN18 = 4;
  localparam int HI_PIN17 = 2;
  localparam int HI_PIN16 = 0;
  localparam int MID_PIN15 = 14;
  localparam int MID_PIN14 = 12;
  localparam int MID_PIN13 = 10;
  localparam int MID_PIN12 = 8;
  localparam int MID_PIN11 = 6;
  localparam int MID_PIN10 = 4;
  localparam int MID_PIN9 = 2;
  localparam int MID_PIN8 = 0;

  // two-bit field codes
  localparam logic [1:0] CODE_GPIO = 2'b00;
  localparam logic [1:0] CODE_ALT1 = 2'b01;
  localparam logic [1:0] CODE_ALT2 = 2'b10;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // level given to a peripheral input whose pin is not routed to it
  localparam logic IDLE_ACTIVE_LOW = 1'b1;
  localparam logic IDLE_TIMER_CLK = 1'b0;

endpackage : pin_function_pkg

// ### fn_unit_model.sv
// behavioural model of the on-chip units feeding function outputs
`timescale 1ns/10ps
module fn_unit_model (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // levels the bench asks each unit to present
  input wire logic [12:0] i_level,
  // function outputs toward the selector
  output logic [12:0] o_fn
);
  // registered like the real units, so a new level lands one cycle late
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      o_fn <= 13'h1FFF; // strobes and selects idle high
    else
      o_fn <= i_level;
  end
endmodule : fn_unit_model

// ### pin_function_chk.sv
// port-level assertions for the pin function selector
`timescale 1ns/10ps
module pin_function_chk
  import pin_function_pkg::*;
(
  // clock, reset and straps
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_single_chip,
  input wire logic i_rom_disabled,
  input wire logic i_large_package,
  // register bus
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic [1:0] o_bresp,
  input wire logic o_bvalid,
  input wire logic i_bready,
  input wire logic [3:0] i_araddr,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic [31:0] o_rdata,
  input wire logic [1:0] o_rresp,
  input wire logic o_rvalid,
  input wire logic i_rready,
  // pin side
  input wire logic [22:8] i_gpio_oe,
  input wire logic i_read_strobe,
  input wire logic [22:8] o_pin_out,
  input wire logic [22:8] o_pin_oe
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  // pin checks skip the edge after reset, whose pins still hold reset values
  a_bresp_hold: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response changed before taken");
  a_rdata_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data changed before taken");
  a_write_answer: assert property (i_awvalid && o_awready && i_wvalid && o_wready
    |-> ##[1:3] o_bvalid) else $error("write response late");
  a_read_answer: assert property (i_arvalid && o_arready |-> ##[1:2] o_rvalid)
    else $error("read data late");
  a_addr_busy: assert property (i_arvalid && o_arready |=> !o_arready)
    else $error("second read taken while one is open");
  a_rdata_upper: assert property (o_rvalid |-> o_rdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  a_bad_read: assert property (i_arvalid && o_arready && i_araddr[1:0] != 2'b00
    |-> ##[1:2] o_rvalid && o_rresp == RESP_SLVERR) else $error("bad offset accepted");
  a_single_gpio: assert property (!$past(i_rst) && $past(i_single_chip)
    && $past(i_large_package) |-> o_pin_oe[22:16] == $past(i_gpio_oe[22:16])
    && o_pin_oe[14:10] == $past(i_gpio_oe[14:10])) else $error("bus function in single chip");
  a_rom_force: assert property (!$past(i_rst) && !$past(i_single_chip)
    && $past(i_rom_disabled) |-> o_pin_oe[14:10] == 5'h1F
    && o_pin_out[14] == $past(i_read_strobe)) else $error("bus pins not forced");
  a_small_pkg: assert property (!$past(i_rst) && !$past(i_large_package)
    |-> o_pin_oe[22:16] == 7'h00 && o_pin_out[22:16] == 7'h00)
    else $error("small package drives high pins");
endmodule : pin_function_chk

bind pin_function_select pin_function_chk pin_function_chk_inst (.i_clk, .i_rst,
  .i_single_chip, .i_rom_disabled, .i_large_package, .i_awvalid, .o_awready, .i_wvalid,
  .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata,
  .o_rresp, .o_rvalid, .i_rready, .i_gpio_oe, .i_read_strobe, .o_pin_out, .o_pin_oe);

// ### tb.sv
// self-checking bench for the pin function selector
`timescale 1ns/10ps
module tb
  import pin_function_pkg::*;
;
  // ----------------------------------------------------------------
  // signals, pin table and instances
  // ----------------------------------------------------------------
  logic i_clk, i_rst, i_single_chip, i_rom_disabled, i_large_package;
  logic [3:0] i_awaddr, i_araddr, i_wstrb;
  logic [31:0] i_wdata;
  logic i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic [22:8] i_gpio_out, i_gpio_oe, i_pin;
  logic [12:0] lvl;
  wire [12:0] fn;
  wire o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  wire [1:0] o_bresp, o_rresp;
  wire [31:0] o_rdata;
  wire [22:8] o_pin_out, o_pin_oe;
  wire o_bus_release_request, o_wait_request, o_timer_ext_clock_c, o_timer_ext_clock_d;
  wire o_ext_interrupt_two, o_ext_interrupt_three;
  int n_mismatch;
  int n_checks;
  // output-function pins, in the order of fn, and which ones rom-disabled forces
  localparam int OP[10] = '{22, 21, 20, 16, 15, 14, 13, 12, 11, 10};
  localparam bit FRC[10] = '{1, 0, 0, 0, 0, 1, 1, 1, 1, 1};

  fn_unit_model fn_unit_model_inst (.i_clk, .i_rst, .i_level(lvl), .o_fn(fn));
  pin_function_select pin_function_select_inst (
    .i_upper_word_low_byte_write_strobe(fn[0]),
    .i_column_strobe_upper_upper(fn[1]),
    .i_column_strobe_upper_lower(fn[2]),
    .i_address_hold_strobe(fn[3]),
    .i_system_clock(fn[4]),
    .i_read_strobe(fn[5]),
    .i_upper_byte_write_strobe(fn[6]),
    .i_lower_byte_write_strobe(fn[7]),
    .i_chip_select_one(fn[8]),
    .i_chip_select_zero(fn[9]),
    .i_bus_release_ack(fn[10]),
    .i_dma1_request_accepted(fn[11]),
    .i_dma0_request_accepted(fn[12]),
    .*
  );

  // 200 MHz clock
  initial
  begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic print_verdict();
    if (n_mismatch == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask : chk

  // one edge of a bounded wait; a stuck handshake ends the run
  task automatic tick(inout int k);
    @(posedge i_clk);
    k++;
    if (k > 40)
    begin
      $display("CHECK FAILED handshake expected answer seen none");
      n_mismatch++;
      print_verdict();
    end
  endtask : tick

  // the leading edge keeps a release and the next raise out of one time step
  task automatic axi_wr(input logic [3:0] a, input logic [15:0] d, input logic [1:0] er);
    int k;
    @(posedge i_clk);
    k = 0;
    i_awaddr <= a;
    i_wdata <= {16'h0000, d};
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    do
    begin
      tick(k);
      if (o_awready)
        i_awvalid <= 1'b0;
      if (o_wready)
        i_wvalid <= 1'b0;
    end
    while (!o_bvalid);
    chk("bresp", 32'(er), 32'(o_bresp));
    i_bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
    int k;
    @(posedge i_clk);
    k = 0;
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    do
    begin
      tick(k);
      if (o_arready)
        i_arvalid <= 1'b0;
    end
    while (!o_rvalid);
    chk("rdata", e, o_rdata);
    chk("rresp", 32'(er), 32'(o_rresp));
    i_rready <= 1'b0;
  endtask : axi_rd

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_vals();
    axi_rd(ADDR_HIGH, 32'h0000_0000, RESP_OKAY);
    axi_rd(ADDR_MIDDLE, 32'h0000_4000, RESP_OKAY);
    axi_rd(ADDR_LOW, 32'h0000_0000, RESP_OKAY);
    axi_rd(ADDR_MODE, 32'h0000_0004, RESP_OKAY);
    chk("pin15_oe", 32'h0000_0001, 32'(o_pin_oe[15]));
  endtask : t_reset_vals

  task automatic t_reserved();
    axi_wr(ADDR_HIGH, 16'hFFFF, RESP_OKAY);
    axi_rd(ADDR_HIGH, {16'h0000, MASK_HIGH}, RESP_OKAY);
    axi_wr(ADDR_MIDDLE, 16'hFFFF, RESP_OKAY);
    axi_rd(ADDR_MIDDLE, {16'h0000, MASK_MIDDLE}, RESP_OKAY);
    axi_wr(ADDR_LOW, 16'hFFFF, RESP_OKAY);
    i_wstrb <= 4'h1;
    axi_wr(ADDR_LOW, 16'h0000, RESP_OKAY);
    i_wstrb <= 4'hF;
    axi_rd(ADDR_LOW, {16'h0000, MASK_LOW & 16'hFF00}, RESP_OKAY);
    axi_wr(ADDR_MODE, 16'hFFFF, RESP_SLVERR);
    axi_rd(ADDR_MODE, 32'h0000_0004, RESP_OKAY);
    axi_wr(4'h2, 16'h1505, RESP_SLVERR);
    axi_rd(4'h2, 32'h0000_0000, RESP_SLVERR);
  endtask : t_reserved

  // all single-bit fields on or off, code c in every two-bit field
  task automatic pins(input logic on, input int c, input logic s, r, l);
    logic [22:8] eo, ee;
    logic [12:0] f;
    logic a;
    f = c[0] ? 13'h0B5A : 13'h14A5;
    lvl <= f;
    i_single_chip <= s;
    i_rom_disabled <= r;
    i_large_package <= l;
    i_pin <= (c == 1) ? 15'h79FF : 15'h0000;
    axi_wr(ADDR_HIGH, on ? 16'h1505 | 16'(c * 16'h0050) : 16'h0000, RESP_OKAY);
    axi_wr(ADDR_MIDDLE, on ? 16'h5550 | 16'(c * 16'h0005) : 16'h0000, RESP_OKAY);
    repeat (3) @(posedge i_clk);
    eo = i_gpio_out;
    ee = i_gpio_oe;
    a = on && !s;
    for (int p = 0; p < 10; p++)
    begin
      if ((on && (!s || OP[p] == 15)) || (r && !s && FRC[p]))
      begin
        eo[OP[p]] = f[p];
        ee[OP[p]] = 1'b1;
      end
    end
    if (a && c == 1)
    begin
      eo[19] = f[10];
      ee[19:18] = 2'b10;
    end
    if (a && c == 2)
    begin
      eo[19:18] = {f[11], f[12]};
      ee[19:18] = 2'b11;
    end
    if (a)
      ee[17] = 1'b0;
    if (on && (c == 1 || c == 2))
      ee[9:8] = 2'b00;
    if (!l)
    begin
      eo[22:16] = 7'h00;
      ee[22:16] = 7'h00;
    end
    chk("pin_oe", 32'(ee), 32'(o_pin_oe));
    chk("pin_out", 32'(eo & ee), 32'(o_pin_out & ee));
    chk("bus_req", 32'((a && c == 1) ? i_pin[18] : 1'b1), 32'(o_bus_release_request));
    chk("wait_req", 32'(a ? i_pin[17] : 1'b1), 32'(o_wait_request));
    chk("tclk_c", 32'((on && c == 1) ? i_pin[8] : 1'b0), 32'(o_timer_ext_clock_c));
    chk("tclk_d", 32'((on && c == 1) ? i_pin[9] : 1'b0), 32'(o_timer_ext_clock_d));
    chk("ext_interrupt_two", 32'((on && c == 2) ? i_pin[8] : 1'b1), 32'(o_ext_interrupt_two));
    chk("ext_interrupt_three", 32'((on && c == 2) ? i_pin[9] : 1'b1), 32'(o_ext_interrupt_three));
  endtask : pins

  task automatic t_power_on_single();
    @(posedge i_clk);
    i_single_chip <= 1'b1;
    i_large_package <= 1'b1;
    i_rst <= 1'b1;
    repeat (16) @(posedge i_clk);
    i_rst <= 1'b0;
    axi_rd(ADDR_MIDDLE, 32'h0000_0000, RESP_OKAY);
    axi_rd(ADDR_LOW, 32'h0000_0000, RESP_OKAY);
    axi_rd(ADDR_MODE, 32'h0000_0005, RESP_OKAY);
  endtask : t_power_on_single

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    n_mismatch = 0;
    n_checks = 0;
    i_rst = 1'b1;
    i_single_chip = 1'b0;
    i_rom_disabled = 1'b0;
    i_large_package = 1'b1;
    i_awaddr = 4'h0;
    i_araddr = 4'h0;
    i_wstrb = 4'hF;
    i_wdata = 32'h0000_0000;
    {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 5'h00;
    i_gpio_out = 15'h2A55;
    i_gpio_oe = 15'h0603; // only input-function pins drive as gpio
    i_pin = 15'h0000;
    lvl = 13'h0000;
    repeat (16) @(posedge i_clk);
    i_rst <= 1'b0;
    t_reset_vals();
    t_reserved();
    pins(1'b1, 1, 1'b0, 1'b0, 1'b1);
    pins(1'b1, 2, 1'b0, 1'b0, 1'b1);
    pins(1'b1, 3, 1'b0, 1'b0, 1'b1);
    pins(1'b1, 1, 1'b1, 1'b0, 1'b1);
    pins(1'b1, 2, 1'b1, 1'b1, 1'b1);
    pins(1'b0, 0, 1'b0, 1'b1, 1'b1);
    pins(1'b0, 0, 1'b0, 1'b0, 1'b0);
    t_power_on_single();
    print_verdict();
  end
endmodule : tb
